// ===== rtl/ftm_fault_trip_manager.sv
// Local design decisions: the register addresses and the strobed register port.
`default_nettype none

module ftm_fault_trip_manager
    import ftm_pkg::*;
#(
    parameter int NUM_CODES = FTM_NUM_CODES,
    parameter int FLASH_CYCLES = FTM_FLASH_CYCLES
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Register port
    input wire logic [FTM_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // Monitored conditions, bit n is code n+1
    input wire logic [NUM_CODES-1:0] condition_in,
    // Reset sources and run command
    input wire logic panel_reset_in,
    input wire logic digital_reset_in,
    input wire logic serial_reset_in,
    input wire logic auto_run_in,
    input wire logic lock_history_in,
    // Drive and indicators
    output logic motor_enable_out,
    output logic detect_enable_out,
    output logic lock_record_out,
    output logic warn_led_out,
    output logic alarm_led_out,
    output logic display_on_out,
    output logic [FTM_CODE_W-1:0] display_code_out,
    // Interrupt
    output logic irq_out
);

    // ****************************************************
    // Configuration registers
    // ****************************************************
    ftm_cfg_type cfg_q;
    ftm_cfg_type cfg_d;
    logic [FTM_NUM_EV-1:0] irq_mask_q;
    logic [FTM_NUM_EV-1:0] irq_mask_d;

    always_comb
    begin
        cfg_d = cfg_q;
        irq_mask_d = irq_mask_q;
        if (reg_write_in && reg_addr_in == FTM_REG_CTRL)
        begin
            cfg_d.auto_reset_en = reg_wdata_in[FTM_CTRL_AUTO];
            cfg_d.digital_reset_en = reg_wdata_in[FTM_CTRL_DIG];
            cfg_d.surface_magnet_rotor_type = reg_wdata_in[FTM_CTRL_SMR];
        end
        if (reg_write_in && reg_addr_in == FTM_REG_OPT)
        begin
            cfg_d.opt_class = reg_wdata_in[FTM_OPT_W-1:0];
        end
        if (reg_write_in && reg_addr_in == FTM_REG_IRQ_MASK)
        begin
            irq_mask_d = reg_wdata_in[FTM_NUM_EV-1:0];
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cfg_q <= '{auto_reset_en: 1'b0, digital_reset_en: 1'b1,
                       surface_magnet_rotor_type: 1'b0,
                       opt_class: FTM_OPT_RESET};
            irq_mask_q <= '0;
        end
        else
        begin
            cfg_q <= cfg_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ****************************************************
    // Condition classification
    // ****************************************************
    logic [NUM_CODES-1:0] warn_mask;
    logic [NUM_CODES-1:0] trip_mask;
    logic [NUM_CODES-1:0] lock_mask;
    logic [NUM_CODES-1:0] warn_act;
    logic [NUM_CODES-1:0] trip_act;
    logic [NUM_CODES-1:0] lock_act;
    logic [FTM_CODE_W-1:0] warn_code;
    logic [FTM_CODE_W-1:0] trip_code;
    logic [1:0] grp_class;

    always_comb
    begin
        grp_class = '0;
        warn_mask = FTM_WARN_FIXED[NUM_CODES-1:0];
        trip_mask = FTM_TRIP_FIXED[NUM_CODES-1:0];
        lock_mask = FTM_LOCK_FIXED[NUM_CODES-1:0];
        for (int g = 0; g < FTM_NUM_GROUPS; g++)
        begin
            grp_class = cfg_q.opt_class[2*g +: 2];
            if (grp_class >= FTM_OPT_WARN)
            begin
                warn_mask = warn_mask | FTM_GRP_MASK[g][NUM_CODES-1:0];
            end
            if (grp_class >= FTM_OPT_TRIP)
            begin
                trip_mask = trip_mask | FTM_GRP_MASK[g][NUM_CODES-1:0];
            end
            if (grp_class == FTM_OPT_LOCK)
            begin
                lock_mask = lock_mask | FTM_GRP_MASK[g][NUM_CODES-1:0];
            end
        end
        if (cfg_q.surface_magnet_rotor_type)
        begin
            warn_mask = warn_mask & ~FTM_PHASE_MASK[NUM_CODES-1:0];
            trip_mask = trip_mask & ~FTM_PHASE_MASK[NUM_CODES-1:0];
            lock_mask = lock_mask & ~FTM_PHASE_MASK[NUM_CODES-1:0];
        end
        // Live every cycle, whatever the state
        warn_act = condition_in & warn_mask;
        trip_act = condition_in & trip_mask;
        lock_act = condition_in & lock_mask;
        // Lowest code wins when several are active
        warn_code = '0;
        trip_code = '0;
        for (int i = NUM_CODES - 1; i >= 0; i--)
        begin
            if (warn_act[i])
            begin
                warn_code = FTM_CODE_W'(i + 1);
            end
            if (trip_act[i])
            begin
                trip_code = FTM_CODE_W'(i + 1);
            end
        end
    end

    // ****************************************************
    // Trip state machine
    // ****************************************************
    ftm_state_type state_q;
    ftm_state_type state_d;
    logic [FTM_CODE_W-1:0] code_q;
    logic [FTM_CODE_W-1:0] code_d;
    logic reset_req;
    logic reset_ok;
    logic trip_present;

    always_comb
    begin
        state_d = state_q;
        code_d = code_q;
        trip_present = |trip_act;
        // Single request from all sources; auto only off the plain trip
        reset_req = panel_reset_in || serial_reset_in
            || (digital_reset_in && cfg_q.digital_reset_en)
            || (cfg_q.auto_reset_en && state_q == FTM_ST_TRIPPED);
        reset_ok = reset_req && !trip_present;
        unique case (state_q)
            FTM_ST_INIT:
            begin
                // Lock survived the power cycle only as a plain trip
                if (lock_history_in)
                begin
                    state_d = FTM_ST_TRIPPED;
                end
                else
                begin
                    state_d = FTM_ST_RUN;
                end
            end
            FTM_ST_RUN, FTM_ST_WAIT_AUTO:
            begin
                if (|lock_act)
                begin
                    state_d = FTM_ST_LOCKED;
                    code_d = trip_code;
                end
                else if (trip_present)
                begin
                    state_d = FTM_ST_TRIPPED;
                    code_d = trip_code;
                end
                else if (state_q == FTM_ST_WAIT_AUTO && auto_run_in)
                begin
                    state_d = FTM_ST_RUN;
                end
            end
            FTM_ST_TRIPPED:
            begin
                if (|lock_act)
                begin
                    state_d = FTM_ST_LOCKED;
                    code_d = trip_code;
                end
                else if (reset_ok)
                begin
                    state_d = panel_reset_in ? FTM_ST_WAIT_AUTO
                                             : FTM_ST_RUN;
                end
            end
            FTM_ST_LOCKED:
            begin
                state_d = FTM_ST_LOCKED;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_q <= FTM_ST_INIT;
            code_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            code_q <= code_d;
        end
    end

    // ****************************************************
    // Flash timer
    // ****************************************************
    logic [31:0] flash_cnt_q;
    logic [31:0] flash_cnt_d;
    logic blink_q;
    logic blink_d;

    always_comb
    begin
        flash_cnt_d = flash_cnt_q + 32'h1;
        blink_d = blink_q;
        if (flash_cnt_q >= 32'(FLASH_CYCLES - 1))
        begin
            flash_cnt_d = '0;
            blink_d = !blink_q;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            flash_cnt_q <= '0;
            blink_q <= 1'b0;
        end
        else
        begin
            flash_cnt_q <= flash_cnt_d;
            blink_q <= blink_d;
        end
    end

    // ****************************************************
    // Drive and indicator outputs
    // ****************************************************
    ftm_ind_type ind_q;
    ftm_ind_type ind_d;
    logic motor_en_q;
    logic motor_en_d;
    logic lock_rec_q;
    logic lock_rec_d;
    logic detect_en_q;
    logic detect_en_d;

    always_comb
    begin
        motor_en_d = state_q == FTM_ST_RUN;
        lock_rec_d = state_q == FTM_ST_LOCKED;
        detect_en_d = !cfg_q.surface_magnet_rotor_type;
        ind_d.warn_led = |warn_act;
        ind_d.alarm_led = 1'b0;
        ind_d.display_on = 1'b1;
        ind_d.display_code = warn_code;
        unique case (state_q)
            FTM_ST_TRIPPED:
            begin
                ind_d.warn_led = trip_present && blink_q;
                ind_d.alarm_led = blink_q;
                ind_d.display_on = blink_q;
                ind_d.display_code = code_q;
            end
            FTM_ST_LOCKED:
            begin
                ind_d.warn_led = 1'b1;
                ind_d.alarm_led = blink_q;
                ind_d.display_on = blink_q;
                ind_d.display_code = code_q;
            end
            FTM_ST_INIT:
            begin
                ind_d.warn_led = 1'b0;
            end
            FTM_ST_RUN, FTM_ST_WAIT_AUTO:
            begin
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ind_q <= '0;
            motor_en_q <= 1'b0;
            lock_rec_q <= 1'b0;
            detect_en_q <= 1'b0;
        end
        else
        begin
            ind_q <= ind_d;
            motor_en_q <= motor_en_d;
            lock_rec_q <= lock_rec_d;
            detect_en_q <= detect_en_d;
        end
    end

    assign motor_enable_out = motor_en_q;
    assign lock_record_out = lock_rec_q;
    assign detect_enable_out = detect_en_q;
    assign warn_led_out = ind_q.warn_led;
    assign alarm_led_out = ind_q.alarm_led;
    assign display_on_out = ind_q.display_on;
    assign display_code_out = ind_q.display_code;

    // ****************************************************
    // Interrupt status
    // ****************************************************
    logic [FTM_NUM_EV-1:0] irq_st_q;
    logic [FTM_NUM_EV-1:0] irq_st_d;
    logic [FTM_NUM_EV-1:0] events;
    logic [FTM_NUM_EV-1:0] w1c;
    logic warn_any_q;
    logic irq_q;
    logic irq_d;

    always_comb
    begin
        events = '0;
        events[FTM_EV_WARN] = (|warn_act) && !warn_any_q;
        events[FTM_EV_TRIP] = state_d == FTM_ST_TRIPPED
            && state_q != FTM_ST_TRIPPED;
        events[FTM_EV_LOCK] = state_d == FTM_ST_LOCKED
            && state_q != FTM_ST_LOCKED;
        events[FTM_EV_CLEAR] = state_q == FTM_ST_TRIPPED && reset_ok;
        w1c = '0;
        if (reg_write_in && reg_addr_in == FTM_REG_IRQ_ST)
        begin
            w1c = reg_wdata_in[FTM_NUM_EV-1:0];
        end
        // Set beats clear so a same-cycle event is kept
        irq_st_d = (irq_st_q & ~w1c) | events;
        irq_d = |(irq_st_d & irq_mask_d);
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            irq_st_q <= '0;
            warn_any_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_st_q <= irq_st_d;
            warn_any_q <= |warn_act;
            irq_q <= irq_d;
        end
    end

    assign irq_out = irq_q;

    // ****************************************************
    // Register read port
    // ****************************************************
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb
    begin
        rdata_d = '0;
        if (reg_read_in)
        begin
            unique case (reg_addr_in)
                FTM_REG_CTRL:
                begin
                    rdata_d[FTM_CTRL_AUTO] = cfg_q.auto_reset_en;
                    rdata_d[FTM_CTRL_DIG] = cfg_q.digital_reset_en;
                    rdata_d[FTM_CTRL_SMR] = cfg_q.surface_magnet_rotor_type;
                end
                FTM_REG_OPT:
                begin
                    rdata_d[FTM_OPT_W-1:0] = cfg_q.opt_class;
                end
                FTM_REG_STATE:
                begin
                    rdata_d[$bits(ftm_state_type)-1:0] = state_q;
                    rdata_d[FTM_STATE_CODE_LSB +: FTM_CODE_W] = code_q;
                end
                FTM_REG_WARN:
                begin
                    rdata_d[NUM_CODES-1:0] = warn_act;
                end
                FTM_REG_TRIP:
                begin
                    rdata_d[NUM_CODES-1:0] = trip_act;
                end
                FTM_REG_IRQ_ST:
                begin
                    rdata_d[FTM_NUM_EV-1:0] = irq_st_q;
                end
                FTM_REG_IRQ_MASK:
                begin
                    rdata_d[FTM_NUM_EV-1:0] = irq_mask_q;
                end
                default:
                begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

endmodule

`default_nettype wire

// ===== rtl/ftm_pkg.sv
`default_nettype none

package ftm_pkg;

    // ****************************************************
    // Fault code classes (bit n stands for code n+1)
    // ****************************************************
    localparam int FTM_NUM_CODES = 32;
    localparam int FTM_CODE_W = 6;
    localparam logic [31:0] FTM_WARN_FIXED = 32'h000039F1;
    localparam logic [31:0] FTM_TRIP_FIXED = 32'h0000F9C0;
    localparam logic [31:0] FTM_LOCK_FIXED = 32'h0000D000;
    localparam logic [31:0] FTM_PHASE_MASK = 32'hE0000000;

    // Optional codes, one 2-bit class setting per group
    localparam int FTM_NUM_GROUPS = 5;
    localparam logic [31:0] FTM_GRP_MASK [FTM_NUM_GROUPS] = '{
        32'h00000002,
        32'h00000004,
        32'h00000008,
        32'h00000600,
        32'hE0000000
    };
    localparam logic [1:0] FTM_OPT_WARN = 2'h1;
    localparam logic [1:0] FTM_OPT_TRIP = 2'h2;
    localparam logic [1:0] FTM_OPT_LOCK = 2'h3;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam int FTM_ADDR_W = 8;
    localparam logic [7:0] FTM_REG_CTRL = 8'h00;
    localparam logic [7:0] FTM_REG_OPT = 8'h04;
    localparam logic [7:0] FTM_REG_STATE = 8'h08;
    localparam logic [7:0] FTM_REG_WARN = 8'h0C;
    localparam logic [7:0] FTM_REG_TRIP = 8'h10;
    localparam logic [7:0] FTM_REG_IRQ_ST = 8'h14;
    localparam logic [7:0] FTM_REG_IRQ_MASK = 8'h18;
    localparam int FTM_CTRL_AUTO = 0;
    localparam int FTM_CTRL_DIG = 1;
    localparam int FTM_CTRL_SMR = 2;
    localparam int FTM_OPT_W = 2 * FTM_NUM_GROUPS;
    localparam logic [9:0] FTM_OPT_RESET = 10'h2AA;
    localparam int FTM_STATE_CODE_LSB = 8;

    // Interrupt events
    localparam int FTM_NUM_EV = 4;
    localparam int FTM_EV_WARN = 0;
    localparam int FTM_EV_TRIP = 1;
    localparam int FTM_EV_LOCK = 2;
    localparam int FTM_EV_CLEAR = 3;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int FTM_CLK_MHZ = 100;
    localparam int FTM_FLASH_HALF_MS = 250;
    localparam int FTM_FLASH_CYCLES = FTM_FLASH_HALF_MS * 1000 * FTM_CLK_MHZ;

    typedef enum logic [2:0] {
        FTM_ST_INIT,
        FTM_ST_RUN,
        FTM_ST_WAIT_AUTO,
        FTM_ST_TRIPPED,
        FTM_ST_LOCKED
    } ftm_state_type;

    typedef struct packed {
        logic auto_reset_en;
        logic digital_reset_en;
        logic surface_magnet_rotor_type;
        logic [FTM_OPT_W-1:0] opt_class;
    } ftm_cfg_type;

    typedef struct packed {
        logic warn_led;
        logic alarm_led;
        logic display_on;
        logic [FTM_CODE_W-1:0] display_code;
    } ftm_ind_type;

endpackage

`default_nettype wire

// ===== verification/ftm_monitor.sv
`default_nettype none

// ********************
// Fault trip checker
// ********************
module ftm_monitor
    import ftm_pkg::*;
#(parameter int NUM_CODES = FTM_NUM_CODES)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Register port
    input wire logic [FTM_ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    // Faults and drive
    input wire logic [NUM_CODES-1:0] condition_in,
    input wire logic motor_enable_out,
    input wire logic detect_enable_out,
    input wire logic lock_record_out,
    input wire logic warn_led_out,
    input wire logic [FTM_CODE_W-1:0] display_code_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    AST_TRIP_STOP: assert property (
        (|(condition_in & FTM_TRIP_FIXED[NUM_CODES-1:0]))[*2]
        |-> ##1 !motor_enable_out) else $error("Motor on in trip");
    AST_LOCK_HOLD: assert property (
        lock_record_out |=> lock_record_out)
        else $error("Lock released");
    AST_LOCK_LED: assert property (
        lock_record_out |-> warn_led_out && !motor_enable_out)
        else $error("Lock LEDs wrong");
    AST_WARN_ONLY: assert property (
        (condition_in == NUM_CODES'(1))[*3] ##0 motor_enable_out
        |-> warn_led_out) else $error("Warn LED off");
    AST_CAUSE_GONE: assert property (
        (condition_in == '0)[*3] ##0 !lock_record_out |-> !warn_led_out)
        else $error("Warn LED on idle");
    AST_TRIP_CODE: assert property (
        (condition_in == NUM_CODES'(64))[*3] ##0 !lock_record_out
        |-> display_code_out == 6'h07) else $error("Display code not 7");
    AST_DETECT: assert property (
        reg_write_in && reg_addr_in == FTM_REG_CTRL
        |-> ##2 detect_enable_out != $past(reg_wdata_in[FTM_CTRL_SMR], 2))
        else $error("Detect enable wrong");
    AST_RD_IDLE: assert property (
        !reg_read_in |=> reg_rdata_out == 32'h0)
        else $error("Stray read data");
    AST_RD_UNMAPPED: assert property (
        reg_read_in && reg_addr_in == 8'h40 |=> reg_rdata_out == 32'h0)
        else $error("Unmapped read");

    COV_TRIP: cover property ($fell(motor_enable_out));
    COV_LOCK: cover property ($rose(lock_record_out));
    COV_IRQ: cover property ($rose(irq_out));
    COV_SMR: cover property (!detect_enable_out);
endmodule

bind ftm_fault_trip_manager ftm_monitor #(.NUM_CODES(NUM_CODES)) mon (
    .clock_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .condition_in, .motor_enable_out,
    .detect_enable_out, .lock_record_out, .warn_led_out,
    .display_code_out, .irq_out);

`default_nettype wire

// ===== verification/ftm_reset_model.sv
`default_nettype none

// ********************
// Reset source side
// ********************
module ftm_reset_model
(
    // Clock
    input wire logic clock_in,
    // Requests from the bench
    input wire logic fire_in,
    input wire logic [1:0] src_in,
    input wire logic [2:0] hold_in,
    input wire logic run_in,
    // Reset sources and run key
    output logic panel_reset_out,
    output logic digital_reset_out,
    output logic serial_reset_out,
    output logic auto_run_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left_q = 3'h0;
    logic [1:0] src_q = 2'h0;

    // Key held a chosen span, so level and pulse both occur
    always @(posedge clock_in)
    begin
        if (fire_in)
        begin
            left_q <= hold_in;
            src_q <= src_in;
        end
        else if (left_q != 3'h0)
            left_q <= left_q - 3'h1;
    end

    assign panel_reset_out = |left_q && src_q == 2'h0;
    assign digital_reset_out = |left_q && src_q == 2'h1;
    assign serial_reset_out = |left_q && src_q == 2'h2;
    assign auto_run_out = run_in;
endmodule

`default_nettype wire

// ===== verification/testbench.sv
`default_nettype none

module testbench
    import ftm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short flash period keeps runs brief
    localparam int FL = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] cond = 32'h0;
    logic wr = 1'b0, rd = 1'b0, hist = 1'b0, fire = 1'b0, run = 1'b0;
    logic [1:0] src = 2'h0;
    logic [2:0] hold = 3'h1;
    logic pnl, dig, ser, arun, motor, det, lrec, wled, aled, don, irq;
    logic [31:0] rdata;
    logic [5:0] dcode;
    int fail_count = 0;
    int n_tests = 0;
    int trips[5] = '{7, 8, 9, 12, 14};
    int gcode[5] = '{2, 3, 4, 11, 31};

    always #5 clock_in = ~clock_in;

    ftm_reset_model keys (.clock_in, .fire_in(fire),
        .src_in(src), .hold_in(hold), .run_in(run),
        .panel_reset_out(pnl), .digital_reset_out(dig),
        .serial_reset_out(ser), .auto_run_out(arun));

    ftm_fault_trip_manager #(.NUM_CODES(32), .FLASH_CYCLES(FL)) dut (
        .clock_in, .reset_in, .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .condition_in(cond),
        .panel_reset_in(pnl), .digital_reset_in(dig),
        .serial_reset_in(ser), .auto_run_in(arun),
        .lock_history_in(hist), .motor_enable_out(motor),
        .detect_enable_out(det), .lock_record_out(lrec),
        .warn_led_out(wled), .alarm_led_out(aled),
        .display_on_out(don), .display_code_out(dcode), .irq_out(irq));

    // ********************
    // Helpers
    // ********************
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
        input logic [31:0] m, exp);
        @(posedge clock_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata & m);
    endtask

    task automatic set_cond(input logic [31:0] c);
        @(posedge clock_in);
        cond <= c;
        tick(4);
    endtask

    task automatic press(input logic [1:0] s);
        @(posedge clock_in);
        src <= s;
        hold <= 3'($urandom_range(4, 1));
        fire <= 1'b1;
        @(posedge clock_in);
        fire <= 1'b0;
        tick(8);
    endtask

    // High cycles of each over two flash periods
    task automatic watch(output int a, w, d);
        a = 0;
        w = 0;
        d = 0;
        repeat (4 * FL)
        begin
            tick(1);
            a += int'(aled === 1'b1);
            w += int'(wled === 1'b1);
            d += int'(don === 1'b1);
        end
    endtask

    function automatic logic [5:0] lowest(input logic [31:0] c);
        for (int i = 0; i < 32; i++)
            if (c[i])
                return 6'(i + 1);
        return 6'h0;
    endfunction

    function automatic logic [31:0] blink(input int n);
        return 32'(n > 0 && n < 4 * FL);
    endfunction

    initial
    begin
        #100us;
        fail_count++;
        summarize();
    end

    // ********************
    // Scenarios
    // ********************
    initial
    begin
        logic [31:0] c, cls;
        int code, a, w, d;
        void'($urandom(32'h29E53BBB));
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        tick(3);
        rd_chk("ctrl", FTM_REG_CTRL, ALL, 32'h2);
        rd_chk("opt", FTM_REG_OPT, ALL, 32'h2AA);
        rd_chk("mask", FTM_REG_IRQ_MASK, ALL, 32'h0);
        rd_chk("status", FTM_REG_IRQ_ST, ALL, 32'h0);
        wr_reg(FTM_REG_STATE, 32'h4);
        rd_chk("state", FTM_REG_STATE, ALL, 32'h1);
        rd_chk("unmapped", 8'h40, ALL, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            c = (i == 0) ? 32'h1 : (($urandom & 32'h31) | 32'h10);
            set_cond(c);
            rd_chk("warn", FTM_REG_WARN, ALL, c);
            rd_chk("trip", FTM_REG_TRIP, ALL, 32'h0);
            chk("wled", 32'h1, 32'(wled));
            chk("aled", 32'h0, 32'(aled));
            chk("code", 32'(lowest(c)), 32'(dcode));
        end
        set_cond(32'h0);
        chk("wled off", 32'h0, 32'(wled));
        for (int s = 0; s < 4; s++)
        begin
            code = trips[$urandom_range(4, 0)];
            c = 32'h1 << (code - 1);
            if (s == 3)
                wr_reg(FTM_REG_CTRL, 32'h3);
            set_cond(c);
            chk("motor trip", 32'h0, 32'(motor));
            chk("trip code", 32'(code), 32'(dcode));
            watch(a, w, d);
            chk("flash", 32'h1, blink(a) & blink(w) & blink(d));
            if (s < 3)
                press(2'(s));
            rd_chk("held", FTM_REG_STATE, 32'h7, 32'h3);
            set_cond(32'h0);
            if (s < 3)
            begin
                watch(a, w, d);
                chk("cause gone", 32'h1, blink(a) & 32'(w == 0));
            end
            if (s == 1)
            begin
                wr_reg(FTM_REG_CTRL, 32'h0);
                press(2'h1);
                rd_chk("dig off", FTM_REG_STATE, 32'h7, 32'h3);
                wr_reg(FTM_REG_CTRL, 32'h2);
            end
            if (s < 3)
                press(2'(s));
            rd_chk("cleared", FTM_REG_STATE, 32'h7, 32'(1 + (s == 0)));
            if (s == 0)
            begin
                chk("wait run", 32'h0, 32'(motor));
                @(posedge clock_in);
                run <= 1'b1;
                @(posedge clock_in);
                run <= 1'b0;
                tick(3);
            end
            chk("motor run", 32'h1, 32'(motor));
            wr_reg(FTM_REG_CTRL, 32'h2);
        end
        wr_reg(FTM_REG_CTRL, 32'h3);
        set_cond(32'h1000);
        rd_chk("lock", FTM_REG_STATE, 32'h7, 32'h4);
        chk("lock wled", 32'h1, 32'(wled));
        chk("lock rec", 32'h1, 32'(lrec));
        set_cond(32'h0);
        for (int s = 0; s < 3; s++)
            press(2'(s));
        rd_chk("lock held", FTM_REG_STATE, 32'h7, 32'h4);
        rd_chk("lock mon", FTM_REG_TRIP, ALL, 32'h0);
        hist <= 1'b1;
        reset_in <= 1'b1;
        tick(2);
        reset_in <= 1'b0;
        tick(3);
        hist <= 1'b0;
        rd_chk("power up", FTM_REG_STATE, 32'h7, 32'h3);
        press(2'h2);
        rd_chk("unlock", FTM_REG_STATE, 32'h7, 32'h1);
        wr_reg(FTM_REG_IRQ_ST, 32'hF);
        rd_chk("irq clr", FTM_REG_IRQ_ST, ALL, 32'h0);
        wr_reg(FTM_REG_IRQ_MASK, 32'h2);
        set_cond(32'h40);
        rd_chk("irq st", FTM_REG_IRQ_ST, ALL, 32'h3);
        chk("irq on", 32'h1, 32'(irq));
        wr_reg(FTM_REG_IRQ_MASK, 32'h4);
        tick(2);
        chk("irq masked", 32'h0, 32'(irq));
        wr_reg(FTM_REG_IRQ_MASK, 32'h2);
        wr_reg(FTM_REG_IRQ_ST, 32'h2);
        tick(2);
        chk("irq w1c", 32'h0, 32'(irq));
        set_cond(32'h0);
        press(2'h2);
        rd_chk("irq ev", FTM_REG_IRQ_ST, ALL, 32'h9);
        wr_reg(FTM_REG_CTRL, 32'h6);
        set_cond(32'h20000000);
        chk("smr det", 32'h0, 32'(det));
        chk("smr run", 32'h1, 32'(motor));
        set_cond(32'h0);
        wr_reg(FTM_REG_CTRL, 32'h2);
        for (int g = 0; g < 5; g++)
        begin
            cls = 32'($urandom_range(2, 0));
            c = 32'h1 << (gcode[g] - 1);
            wr_reg(FTM_REG_OPT, (32'h2AA & ~(32'h3 << 2 * g)) | (cls << 2 * g));
            set_cond(c);
            rd_chk("opt warn", FTM_REG_WARN, ALL, (cls != 0) ? c : 0);
            chk("opt run", 32'(cls < 2), 32'(motor));
            set_cond(32'h0);
            press(2'h2);
        end
        summarize();
    end
endmodule

`default_nettype wire
